/* File: include/acp_regs.svh */
/*
  Register offsets, reset values, frame layout and link timing for the
  converter serial control port.
  Assumes inclusion by bare name from package and modules.
*/
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

`define ACP_FRAME_BITS 24
`define ACP_CMD_BITS 8
`define ACP_DATA_BITS 16
`define ACP_ADDR_BITS 4
`define ACP_RSVD_PATTERN 2'h2
`define ACP_OP_READ 1'h1
`define ACP_OP_WRITE 1'h0

`define ACP_OFF_MAIN_CONFIG 4'h0
`define ACP_OFF_RESERVED_1 4'h1
`define ACP_OFF_FIRST_OFFSET 4'h2
`define ACP_OFF_FIRST_RANGE 4'h3
`define ACP_OFF_CAL_ADJUST 4'h4
`define ACP_OFF_CAL_VALUES 4'h5
`define ACP_OFF_BIAS_ADJUST 4'h6
`define ACP_OFF_INTERLEAVE_ADJ 4'h7
`define ACP_OFF_RESERVED_8 4'h8
`define ACP_OFF_RESERVED_9 4'h9
`define ACP_OFF_SECOND_OFFSET 4'hA
`define ACP_OFF_SECOND_RANGE 4'hB
`define ACP_OFF_DELAY_COARSE 4'hC
`define ACP_OFF_DELAY_FINE 4'hD
`define ACP_OFF_MULTI_SYNC 4'hE
`define ACP_OFF_RESERVED_F 4'hF

`define ACP_RST_MAIN_CONFIG 16'h2000
`define ACP_RST_OTHER 16'h0000

`define ACP_CFG_FIRST_PD_BIT 11
`define ACP_CFG_SECOND_PD_BIT 10
`define ACP_CFG_TEST_PAT_BIT 12

`define ACP_WB_CMD 2'h0
`define ACP_WB_STATUS 2'h1
`define ACP_WB_RDATA 2'h2

`define ACP_LINK_DIV 4

`endif

/* File: include/acp_pkg.sv */
/*
  Types shared by both ends of the converter serial control port.
  Assumes acp_regs.svh on the include path.
*/
`include "acp_regs.svh"
package acp_pkg;
  typedef logic [`ACP_DATA_BITS-1:0] acp_word_t;
  typedef logic [`ACP_ADDR_BITS-1:0] acp_addr_t;
  typedef enum logic [1:0] {
    ACP_H_IDLE = 2'h0,
    ACP_H_RUN = 2'h1,
    ACP_H_GAP = 2'h2
  } acp_host_state_t;
endpackage

/* File: include/acp_link_if.sv */
/*
  Serial link between the host master and the converter control port.
  Assumes the bench resolves the shared data wire from the enables.
*/
`timescale 1ns/1ns
`default_nettype none
interface acp_link_if;
  logic serial_select_n;
  logic sclk;
  logic serial_in;
  logic serial_in_oe;
  logic serial_out;
  logic serial_out_oe;
  modport device (
    input serial_select_n, sclk, serial_in,
    output serial_out, serial_out_oe
  );
  modport host (
    output serial_select_n, sclk, serial_in, serial_in_oe,
    input serial_out, serial_out_oe
  );
endinterface
`default_nettype wire

/* File: logic/acp_device.sv */
/*
  Converter end of the serial control port: frame decoder, sixteen-word
  register file and control-mode logic for power-down; test pattern follows its pin in both modes.
  Assumes link pins are asynchronous to clk_i and the link clock is much
  slower than clk_i; pins are synchronised by two flip-flops.
*/
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"
module acp_device #(
  parameter int FRAME_BITS = `ACP_FRAME_BITS
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link
  acp_link_if.device link,
  // Control pins
  input wire logic ext_control_select_pin_i,
  input wire logic first_channel_powerdown_i,
  input wire logic second_channel_powerdown_i,
  input wire logic test_pattern_select_i,
  // Status to converter core
  output logic register_control_mode_o,
  output logic first_channel_pd_o,
  output logic second_channel_pd_o,
  output logic first_channel_data_oe_o,
  output logic second_channel_data_oe_o,
  output logic test_pattern_active_o,
  output acp_pkg::acp_word_t main_configuration_o
);
  import acp_pkg::*;

  initial begin
    if (FRAME_BITS != `ACP_FRAME_BITS) begin
      $error("acp_device: frame length must be 24");
    end
  end

  function automatic logic acp_valid_addr(input acp_addr_t a);
    acp_valid_addr = !(a == `ACP_OFF_RESERVED_1 || a == `ACP_OFF_RESERVED_8
      || a == `ACP_OFF_RESERVED_9 || a == `ACP_OFF_RESERVED_F);
  endfunction

  // Pin synchronisers
  logic [1:0] ss_sync_reg, ck_sync_reg, di_sync_reg, ece_sync_reg;
  logic [1:0] pd1_sync_reg, pd2_sync_reg, tp_sync_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_sync_reg <= 2'h3;
      ck_sync_reg <= 2'h0;
      di_sync_reg <= 2'h0;
      ece_sync_reg <= 2'h3;
      pd1_sync_reg <= 2'h0;
      pd2_sync_reg <= 2'h0;
      tp_sync_reg <= 2'h0;
    end else if (ce_i) begin
      ss_sync_reg <= {ss_sync_reg[0], link.serial_select_n};
      ck_sync_reg <= {ck_sync_reg[0], link.sclk};
      di_sync_reg <= {di_sync_reg[0], link.serial_in};
      ece_sync_reg <= {ece_sync_reg[0], ext_control_select_pin_i};
      pd1_sync_reg <= {pd1_sync_reg[0], first_channel_powerdown_i};
      pd2_sync_reg <= {pd2_sync_reg[0], second_channel_powerdown_i};
      tp_sync_reg <= {tp_sync_reg[0], test_pattern_select_i};
    end
  end

  // Edge detection on the synchronised link clock
  logic ck_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_prev_reg <= 1'h0;
    end else if (ce_i) begin
      ck_prev_reg <= ck_sync_reg[1];
    end
  end
  wire logic sclk_rise = ck_sync_reg[1] & ~ck_prev_reg;
  wire logic sclk_fall = ~ck_sync_reg[1] & ck_prev_reg;
  wire logic sel_active = ~ss_sync_reg[1];
  wire logic register_control_mode = ~ece_sync_reg[1];

  // Frame receiver
  logic [4:0] bit_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic is_read_reg;
  logic write_stb;
  acp_addr_t rx_addr;
  assign rx_addr = shift_reg[4:1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= '0;
      is_read_reg <= 1'h0;
    end else if (ce_i) begin
      if (!sel_active) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise && bit_cnt_reg != 5'(FRAME_BITS)) begin
        shift_reg <= {shift_reg[FRAME_BITS-2:0], di_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == 5'h00) begin
          is_read_reg <= (di_sync_reg[1] == `ACP_OP_READ);
        end
      end
    end
  end
  // Write commits on the 24th rising edge; later clocks are ignored
  assign write_stb = sel_active && sclk_rise && !is_read_reg
    && bit_cnt_reg == 5'(FRAME_BITS - 1);

  // Register file
  acp_word_t regs_mem [16];
  acp_addr_t wr_addr;
  acp_word_t wr_data;
  assign wr_addr = shift_reg[FRAME_BITS-5:FRAME_BITS-8];
  assign wr_data = {shift_reg[`ACP_DATA_BITS-2:0], di_sync_reg[1]};
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && !register_control_mode)) begin
          regs_mem[gi] <= (gi == 0) ? `ACP_RST_MAIN_CONFIG
            : `ACP_RST_OTHER;
        end else if (ce_i && write_stb && wr_addr == 4'(gi)
            && acp_valid_addr(4'(gi))) begin
          regs_mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Read data shifter
  acp_word_t tx_reg;
  logic out_reg, oe_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg <= '0;
      out_reg <= 1'h0;
      oe_reg <= 1'h0;
    end else if (ce_i) begin
      if (!sel_active) begin
        oe_reg <= 1'h0;
      end else if (sclk_fall && is_read_reg && register_control_mode) begin
        if (bit_cnt_reg == 5'(`ACP_CMD_BITS)) begin
          oe_reg <= 1'h1;
          tx_reg <= {regs_mem[rx_addr][`ACP_DATA_BITS-2:0], 1'h0};
          out_reg <= acp_valid_addr(rx_addr)
            ? regs_mem[rx_addr][`ACP_DATA_BITS-1] : 1'h0;
          if (!acp_valid_addr(rx_addr)) begin
            tx_reg <= '0;
          end
        end else if (bit_cnt_reg > 5'(`ACP_CMD_BITS)
            && bit_cnt_reg < 5'(FRAME_BITS)) begin
          out_reg <= tx_reg[`ACP_DATA_BITS-1];
          tx_reg <= {tx_reg[`ACP_DATA_BITS-2:0], 1'h0};
        end
      end
    end
  end
  assign link.serial_out = out_reg;
  assign link.serial_out_oe = oe_reg;

  // Control-mode outputs
  wire logic cfg_pd1 = register_control_mode & regs_mem[0][`ACP_CFG_FIRST_PD_BIT];
  wire logic cfg_pd2 = register_control_mode & regs_mem[0][`ACP_CFG_SECOND_PD_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      register_control_mode_o <= 1'h0;
      first_channel_pd_o <= 1'h0;
      second_channel_pd_o <= 1'h0;
      first_channel_data_oe_o <= 1'h0;
      second_channel_data_oe_o <= 1'h0;
      test_pattern_active_o <= 1'h0;
      main_configuration_o <= `ACP_RST_MAIN_CONFIG;
    end else if (ce_i) begin
      register_control_mode_o <= register_control_mode;
      first_channel_pd_o <= pd1_sync_reg[1] | cfg_pd1;
      second_channel_pd_o <= pd2_sync_reg[1] | cfg_pd2;
      first_channel_data_oe_o <= ~(pd1_sync_reg[1] | cfg_pd1);
      second_channel_data_oe_o <= ~(pd2_sync_reg[1] | cfg_pd2);
      test_pattern_active_o <= tp_sync_reg[1];
      main_configuration_o <= regs_mem[0];
    end
  end
endmodule
`default_nettype wire

/* File: logic/acp_host.sv */
/*
  Host end: a classic Wishbone slave whose command register launches one
  24-bit serial access; link clock made by a divider of clk_i.
  Assumes the device end samples the link with a fast clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"
module acp_host #(
  parameter int HALF_DIV = `ACP_LINK_DIV
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link
  acp_link_if.host link,
  // Mode
  input wire logic three_wire_i
);
  import acp_pkg::*;

  initial begin
    if (HALF_DIV < 2 || HALF_DIV > 255) begin
      $error("acp_host: HALF_DIV out of range");
    end
  end

  acp_host_state_t state_reg;
  logic [23:0] frame_reg;
  logic [4:0] bits_reg;
  logic [7:0] div_reg;
  logic sclk_reg, ss_n_reg, sdi_reg, sdi_oe_reg;
  logic rd_op_reg;
  acp_word_t rdata_reg;
  logic [1:0] so_sync_reg;
  wire logic tick = (div_reg == 8'(HALF_DIV - 1));
  wire logic start = cyc_i && stb_i && we_i && ack_o && sel_i[0]
    && adr_i[3:2] == `ACP_WB_CMD && state_reg == ACP_H_IDLE;

  // Wishbone slave: one-wait answer; word offsets 0,4,8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'h0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
      unique case (adr_i[3:2])
        `ACP_WB_STATUS: dat_o <= {31'h00000000, state_reg != ACP_H_IDLE};
        `ACP_WB_RDATA: dat_o <= {16'h0000, rdata_reg};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_sync_reg <= 2'h0;
    end else if (ce_i) begin
      so_sync_reg <= {so_sync_reg[0], link.serial_out};
    end
  end

  // Serial engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ACP_H_IDLE;
      frame_reg <= 24'h000000;
      bits_reg <= 5'h00;
      div_reg <= 8'h00;
      sclk_reg <= 1'h0;
      ss_n_reg <= 1'h1;
      sdi_reg <= 1'h0;
      sdi_oe_reg <= 1'h0;
      rd_op_reg <= 1'h0;
      rdata_reg <= 16'h0000;
    end else if (ce_i) begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      unique case (state_reg)
        ACP_H_IDLE: begin
          sclk_reg <= 1'h0;
          if (start) begin
            // Op, fixed 10, address, don't-care, data
            frame_reg <= {dat_i[20], `ACP_RSVD_PATTERN, dat_i[19:16], 1'h0,
              dat_i[15:0]};
            ss_n_reg <= 1'h0;
            sdi_reg <= dat_i[20];
            rd_op_reg <= dat_i[20];
            sdi_oe_reg <= 1'h1;
            bits_reg <= 5'h00;
            div_reg <= 8'h00;
            state_reg <= ACP_H_RUN;
          end
        end
        ACP_H_RUN: if (tick) begin
          sclk_reg <= ~sclk_reg;
          if (!sclk_reg) begin
            bits_reg <= bits_reg + 5'h01;
            if (bits_reg > 5'h07) begin
              rdata_reg <= {rdata_reg[14:0], so_sync_reg[1]};
            end
          end else begin
            frame_reg <= {frame_reg[22:0], 1'h0};
            sdi_reg <= frame_reg[22];
            if (bits_reg == 5'h07 && rd_op_reg && three_wire_i) begin
              sdi_oe_reg <= 1'h0;
            end
            if (bits_reg == 5'h18) begin
              ss_n_reg <= 1'h1;
              sdi_oe_reg <= 1'h0;
              state_reg <= ACP_H_GAP;
            end
          end
        end
        ACP_H_GAP: if (tick) begin
          state_reg <= ACP_H_IDLE;
        end
        default: state_reg <= ACP_H_IDLE;
      endcase
    end
  end
  assign link.serial_select_n = ss_n_reg;
  assign link.sclk = sclk_reg;
  assign link.serial_in = sdi_reg;
  assign link.serial_in_oe = sdi_oe_reg;
endmodule
`default_nettype wire

/* File: verification/acp_assertions.sv */
/*
  Checker on the serial link joining host and device ends.
  Assumes it sees the link signals and clk_i/rst_i of the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module acp_assertions (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic serial_select_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // Shared wire
  input wire logic serial_in_oe,
  input wire logic three_wire
);
  logic sclk_q;
  logic [4:0] rise_cnt;
  logic [23:0] frame_sh;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Link clock rises and bits taken in the frame
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || serial_select_n) begin
      rise_cnt <= 5'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!serial_select_n && sclk && !sclk_q) begin
      frame_sh <= {frame_sh[22:0], serial_in};
    end
  end
  sequence frame_end;
    $rose(serial_select_n);
  endsequence
  sequence lsb_phase;
    rise_cnt == 5'h18 && !serial_select_n && serial_out_oe;
  endsequence
  frame_len_a: assert property (frame_end |-> rise_cnt == 5'h18)
    else $error("frame length not 24 clocks");
  oe_idle_a: assert property (serial_select_n [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  sclk_idle_a: assert property (serial_select_n |-> !sclk)
    else $error("link clock not low between frames");
  oe_start_a: assert property ($rose(serial_out_oe) |-> rise_cnt == 5'h08)
    else $error("output not started at 8th clock");
  out_edge_a: assert property ($changed(serial_out) && serial_out_oe |-> !sclk)
    else $error("output changed while clock high");
  fixed_bits_a: assert property (frame_end |-> frame_sh[22:21] == 2'h2)
    else $error("fixed bits not one zero");
  dir_oe_a: assert property (frame_end |-> serial_out_oe == frame_sh[23])
    else $error("output enable does not match direction");
  hold_lsb_a: assert property (lsb_phase |=> $stable(serial_out) || !serial_out_oe)
    else $error("last data bit not held");
  gap_toggle_a: assert property (frame_end |=> serial_select_n [*4])
    else $error("select not toggled between frames");
  turn_free_a: assert property ($rose(serial_out_oe) && three_wire |-> !serial_in_oe)
    else $error("host still drives shared wire");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
  Self-checking bench: host and device joined by the link interface.
  Assumes the host Wishbone map 0 command, 4 status, 8 read data.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic ack, ecs = 1'b1, pd1 = 1'b0, pd2 = 1'b0, tps = 1'b0;
  logic tw = 1'b0;
  logic rcm, pd1_o, pd2_o, oe1, oe2, tpa;
  acp_word_t cfg, q;
  int n_fail = 0, compares = 0;
  always #50 clk_i = ~clk_i;
  acp_link_if link_if();
  acp_host #(.HALF_DIV(8)) acp_host_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(4'hF),
    .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .link(link_if), .three_wire_i(tw));
  acp_device acp_device_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(link_if), .ext_control_select_pin_i(ecs),
    .first_channel_powerdown_i(pd1), .second_channel_powerdown_i(pd2),
    .test_pattern_select_i(tps), .register_control_mode_o(rcm),
    .first_channel_pd_o(pd1_o), .second_channel_pd_o(pd2_o),
    .first_channel_data_oe_o(oe1), .second_channel_data_oe_o(oe2),
    .test_pattern_active_o(tpa), .main_configuration_o(cfg));
  acp_assertions acp_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
    .serial_select_n(link_if.serial_select_n), .sclk(link_if.sclk),
    .serial_in(link_if.serial_in), .serial_out(link_if.serial_out),
    .serial_out_oe(link_if.serial_out_oe),
    .serial_in_oe(link_if.serial_in_oe), .three_wire(tw));
  task chk(input logic [15:0] got, input logic [15:0] exp,
    input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One classic Wishbone cycle
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // One serial access, then wait for idle
  task acc(input logic rd, input acp_addr_t a, input acp_word_t d);
    logic [31:0] r;
    wb(1'b1, 4'h0, {11'h0, rd, a, d}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) wb(1'b0, 4'h4, 32'h0, r);
    if (rd) begin
      wb(1'b0, 4'h8, 32'h0, r);
      q = r[15:0];
    end
  endtask
  task settle;
    repeat (8) @(posedge clk_i);
  endtask
  task t_reset;
    chk(cfg, 16'h2000, "default config");
    chk(16'(rcm), 16'h0000, "pin mode");
    ecs <= 1'b0;
    settle();
    chk(16'(rcm), 16'h0001, "register mode");
  endtask
  task t_rw;
    acc(1'b0, 4'hA, 16'h8001);
    acc(1'b1, 4'hA, 16'h0000);
    chk(q, 16'h8001, "readback");
    acc(1'b1, 4'h0, 16'hFFFF);
    chk(q, 16'h2000, "config read");
  endtask
  task t_rsvd;
    acc(1'b0, 4'h1, 16'h5555);
    acc(1'b1, 4'h1, 16'h0000);
    chk(q, 16'h0000, "reserved read");
    acc(1'b0, 4'h8, 16'h2C00);
    chk(cfg, 16'h2000, "reserved write ignored");
    acc(1'b1, 4'hF, 16'h0000);
    chk(q, 16'h0000, "invalid read");
  endtask
  task t_pd;
    acc(1'b0, 4'h0, 16'h2800);
    settle();
    chk(16'({pd1_o, oe1, pd2_o}), 16'h0004, "first down");
    acc(1'b0, 4'h0, 16'h2400);
    settle();
    chk(16'({pd1_o, pd2_o, oe2}), 16'h0002, "second down");
    acc(1'b0, 4'h0, 16'h2000);
    pd1 <= 1'b1;
    settle();
    chk(16'({pd1_o, pd2_o}), 16'h0002, "pin or bit");
    acc(1'b1, 4'hA, 16'h0000);
    chk(q, 16'h8001, "kept in power-down");
    pd1 <= 1'b0;
  endtask
  task t_3w;
    tw <= 1'b1;
    acc(1'b1, 4'hA, 16'h0000);
    chk(q, 16'h8001, "three-wire read");
    tw <= 1'b0;
  endtask
  task t_pin;
    acc(1'b0, 4'h0, 16'h2C00);
    ecs <= 1'b1;
    settle();
    chk(16'({pd1_o, pd2_o}), 16'h0000, "registers ignored");
    chk(cfg, 16'h2000, "registers reset");
    tps <= 1'b1;
    settle();
    chk(16'(tpa), 16'h0001, "test pattern");
    tps <= 1'b0;
  endtask
  task complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    t_reset();
    t_rw();
    t_rsvd();
    t_pd();
    t_3w();
    t_pin();
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
